// [shared/bsfu_pkg.sv]
/*
 package for the bit, shift and flag unit: register map, command fields,
 flag positions, operation codes and reset values.
 assumes a 12-bit APB byte address and 32-bit data.
*/
package bsfu_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CMD = 12'h000;
   localparam logic [11:0] ADDR_OPERAND = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_STATE = 12'h00c;
   localparam logic [11:0] ADDR_IO_BASE = 12'h040;
   localparam int unsigned IO_SLOT_LSB = 2;
   localparam int unsigned IO_BASE_LSB = 6;

   // ----------------------------------------------------------------
   // command word fields
   // ----------------------------------------------------------------
   localparam int unsigned CMD_OP_LSB = 0;
   localparam int unsigned CMD_OP_W = 5;
   localparam int unsigned CMD_BIT_LSB = 8;
   localparam int unsigned CMD_IO_LSB = 12;

   // ----------------------------------------------------------------
   // status register flag positions
   // ----------------------------------------------------------------
   localparam logic [2:0] FLAG_C = 3'h0;
   localparam logic [2:0] FLAG_Z = 3'h1;
   localparam logic [2:0] FLAG_N = 3'h2;
   localparam logic [2:0] FLAG_V = 3'h3;
   localparam logic [2:0] FLAG_S = 3'h4;
   localparam logic [2:0] FLAG_H = 3'h5;
   localparam logic [2:0] FLAG_T = 3'h6;
   localparam logic [2:0] FLAG_I = 3'h7;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] OPERAND_RST = 8'h00;
   localparam logic [7:0] IO_RST = 8'h00;

   // ----------------------------------------------------------------
   // operations
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NOP = 5'h00,
      OP_IO_BIT_CLEAR = 5'h01,
      OP_IO_BIT_FORCE_ONE = 5'h02,
      OP_LOGIC_SHIFT_LEFT = 5'h03,
      OP_LOGIC_SHIFT_RIGHT = 5'h04,
      OP_ROTATE_LEFT_CARRY = 5'h05,
      OP_ROTATE_RIGHT_CARRY = 5'h06,
      OP_ARITH_SHIFT_RIGHT = 5'h07,
      OP_NIBBLE_EXCHANGE = 5'h08,
      OP_STATUS_FLAG_ON = 5'h09,
      OP_STATUS_FLAG_OFF = 5'h0a,
      OP_BIT_TO_TRANSFER_FLAG = 5'h0b,
      OP_TRANSFER_FLAG_TO_BIT = 5'h0c,
      OP_CARRY_FLAG_ON = 5'h0d,
      OP_CARRY_FLAG_OFF = 5'h0e,
      OP_NEGATIVE_FLAG_ON = 5'h0f,
      OP_NEGATIVE_FLAG_OFF = 5'h10,
      OP_ZERO_FLAG_ON = 5'h11,
      OP_ZERO_FLAG_OFF = 5'h12,
      OP_GLOBAL_IRQ_ON = 5'h13,
      OP_GLOBAL_IRQ_OFF = 5'h14,
      OP_SIGN_FLAG_ON = 5'h15
   } op_e;

   // io bit sequence, gray along idle -> fetch -> store
   typedef enum logic [1:0] {
      IO_IDLE = 2'b00,
      IO_FETCH = 2'b01,
      IO_STORE = 2'b11
   } io_state_e;

endpackage : bsfu_pkg

// [src/shift_rotate_core.sv]
/*
 combinational shift and rotate datapath with carry, zero, negative and
 overflow results.
 assumes the caller registers the outputs and selects the operation.
*/
`timescale 1ns/1ns
module shift_rotate_core import bsfu_pkg::*; (
   input wire op_e op,
   input wire logic [7:0] value,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic carry_out,
   output logic zero_out,
   output logic neg_out,
   output logic ovf_out
);

   always_comb begin
      result = value;
      carry_out = carry_in;
      unique case (op)
         OP_LOGIC_SHIFT_LEFT: begin
            result = {value[6:0], 1'b0};
            carry_out = value[7];
         end
         OP_LOGIC_SHIFT_RIGHT: begin
            result = {1'b0, value[7:1]};
            carry_out = value[0];
         end
         OP_ROTATE_LEFT_CARRY: begin
            result = {value[6:0], carry_in};
            carry_out = value[7];
         end
         OP_ROTATE_RIGHT_CARRY: begin
            result = {carry_in, value[7:1]};
            carry_out = value[0];
         end
         OP_ARITH_SHIFT_RIGHT: begin
            result = {value[7], value[7:1]};
            carry_out = value[0];
         end
         default: begin
            result = value;
            carry_out = carry_in;
         end
      endcase
      zero_out = (result == 8'h00);
      neg_out = result[7];
      ovf_out = result[7] ^ carry_out;
   end

endmodule : shift_rotate_core

// [src/bit_shift_flag_unit.sv]
/*
 bit, shift and flag execution unit with an APB register slave.
 assumes APB master on pclk, asynchronous active-low presetn.
*/
// Notes on behaviour
// RULE_01: io bit clear, flags kept, two cycles
// RULE_02: io bit set, flags kept, two cycles
// RULE_03: shift left, zero in, flags updated
// RULE_04: shift right, zero in, flags updated
// RULE_05: rotate left through carry, one cycle
// RULE_06: rotate right through carry, one cycle
// RULE_07: arithmetic right shift keeps top bit
// RULE_08: nibble exchange, flags untouched, one cycle
// RULE_09: flag on sets selected status bit
// RULE_10: flag off clears selected status bit
// RULE_11: register bit copied into transfer flag
// RULE_12: transfer flag copied into register bit
// RULE_13: single flag set and clear ops
// RULE_14: negative off clears only negative
// RULE_15: global interrupt flag set to one
// RULE_16: global interrupt flag cleared to zero
// RULE_17: sign flag on sets only sign
// RULE_18: zero, negative, overflow from shift result
`timescale 1ns/1ns
module bit_shift_flag_unit import bsfu_pkg::*; #(
   parameter int unsigned NIO = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [7:0] status_q,
   output logic [7:0] operand_q,
   output logic global_irq_en,
   output logic busy
);

   localparam int unsigned IDXW = (NIO > 1) ? $clog2(NIO) : 1;

   if ((NIO < 2) || (NIO > 16) || ((NIO & (NIO - 1)) != 0)) begin : g_bad_nio
      $error("NIO must be a power of two from 2 to 16");
   end

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   io_state_e state_ff, nxt_state;
   logic [7:0] operand_ff, nxt_operand;
   logic [7:0] status_ff, nxt_status;
   logic [7:0] io_ff [NIO];
   logic [7:0] nxt_io [NIO];
   logic [IDXW-1:0] io_idx_ff, nxt_io_idx;
   logic [2:0] io_bit_ff, nxt_io_bit;
   logic io_set_ff, nxt_io_set;
   logic [7:0] io_val_ff, nxt_io_val;
   logic [31:0] prdata_ff, nxt_prdata;

   logic io_hit, reg_hit, hit, access, wr_done, exec;
   logic [IDXW-1:0] io_sel;
   logic [31:0] rd_mux;
   op_e cmd_op;
   logic [2:0] cmd_bit;
   logic [7:0] sh_result;
   logic sh_carry, sh_zero, sh_neg, sh_ovf;

   assign io_sel = paddr[IO_SLOT_LSB +: IDXW];
   assign io_hit = (paddr[11:IO_BASE_LSB] == ADDR_IO_BASE[11:IO_BASE_LSB])
      && ({1'b0, paddr[IO_BASE_LSB-1:IO_SLOT_LSB]} < 5'(NIO)) && (paddr[1:0] == 2'h0);
   assign reg_hit = (paddr == ADDR_CMD) || (paddr == ADDR_OPERAND)
      || (paddr == ADDR_STATUS) || (paddr == ADDR_STATE);
   assign hit = io_hit || reg_hit;
   assign access = psel && penable;
   // writes wait while an io bit sequence runs, so nothing races it
   assign pready = !(penable && pwrite && busy);
   assign pslverr = access && pready && !hit;
   assign wr_done = access && pwrite && pready && hit;
   assign exec = wr_done && (paddr == ADDR_CMD);
   assign cmd_op = op_e'(pwdata[CMD_OP_LSB +: CMD_OP_W]);
   assign cmd_bit = pwdata[CMD_BIT_LSB +: 3];
   assign busy = (state_ff != IO_IDLE);
   assign prdata = prdata_ff;
   assign status_q = status_ff;
   assign operand_q = operand_ff;
   assign global_irq_en = status_ff[FLAG_I];

   shift_rotate_core u_shift (
      .op(cmd_op),
      .value(operand_ff),
      .carry_in(status_ff[FLAG_C]),
      .result(sh_result),
      .carry_out(sh_carry),
      .zero_out(sh_zero),
      .neg_out(sh_neg),
      .ovf_out(sh_ovf)
   );

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_comb begin
      rd_mux = 32'h0;
      if (io_hit) begin
         rd_mux = {24'h0, io_ff[io_sel]};
      end else if (paddr == ADDR_OPERAND) begin
         rd_mux = {24'h0, operand_ff};
      end else if (paddr == ADDR_STATUS) begin
         rd_mux = {24'h0, status_ff};
      end else if (paddr == ADDR_STATE) begin
         rd_mux = {29'h0, busy, state_ff};
      end
      nxt_prdata = prdata_ff;
      if (psel && !pwrite) begin
         nxt_prdata = rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // execution
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_operand = operand_ff;
      nxt_status = status_ff;
      nxt_io = io_ff;
      nxt_io_idx = io_idx_ff;
      nxt_io_bit = io_bit_ff;
      nxt_io_set = io_set_ff;
      nxt_io_val = io_val_ff;
      if (wr_done && io_hit) begin
         nxt_io[io_sel] = pwdata[7:0];
      end
      if (wr_done && (paddr == ADDR_OPERAND)) begin
         nxt_operand = pwdata[7:0];
      end
      if (wr_done && (paddr == ADDR_STATUS)) begin
         nxt_status = pwdata[7:0];
      end
      if (exec) begin
         unique case (cmd_op)
            // RULE_01 RULE_02 start io sequence
            OP_IO_BIT_CLEAR, OP_IO_BIT_FORCE_ONE: begin
               nxt_state = IO_FETCH;
               nxt_io_idx = pwdata[CMD_IO_LSB +: IDXW];
               nxt_io_bit = cmd_bit;
               nxt_io_set = (cmd_op == OP_IO_BIT_FORCE_ONE);
            end
            // RULE_03 RULE_04 RULE_05 RULE_06 RULE_07 shift datapath
            OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
            OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT: begin
               nxt_operand = sh_result;
               nxt_status[FLAG_C] = sh_carry;
               // RULE_18 flags from result
               nxt_status[FLAG_Z] = sh_zero;
               nxt_status[FLAG_N] = sh_neg;
               nxt_status[FLAG_V] = sh_ovf;
            end
            // RULE_08 swap nibbles
            OP_NIBBLE_EXCHANGE: nxt_operand = {operand_ff[3:0], operand_ff[7:4]};
            // RULE_09 selected flag on
            OP_STATUS_FLAG_ON: nxt_status[cmd_bit] = 1'b1;
            // RULE_10 selected flag off
            OP_STATUS_FLAG_OFF: nxt_status[cmd_bit] = 1'b0;
            // RULE_11 bit into transfer flag
            OP_BIT_TO_TRANSFER_FLAG: nxt_status[FLAG_T] = operand_ff[cmd_bit];
            // RULE_12 transfer flag into bit
            OP_TRANSFER_FLAG_TO_BIT: nxt_operand[cmd_bit] = status_ff[FLAG_T];
            // RULE_13 carry and zero set/clear
            OP_CARRY_FLAG_ON: nxt_status[FLAG_C] = 1'b1;
            OP_CARRY_FLAG_OFF: nxt_status[FLAG_C] = 1'b0;
            OP_ZERO_FLAG_ON: nxt_status[FLAG_Z] = 1'b1;
            OP_ZERO_FLAG_OFF: nxt_status[FLAG_Z] = 1'b0;
            // RULE_13 negative set
            OP_NEGATIVE_FLAG_ON: nxt_status[FLAG_N] = 1'b1;
            // RULE_14 negative clear
            OP_NEGATIVE_FLAG_OFF: nxt_status[FLAG_N] = 1'b0;
            // RULE_15 interrupts enabled
            OP_GLOBAL_IRQ_ON: nxt_status[FLAG_I] = 1'b1;
            // RULE_16 interrupts disabled
            OP_GLOBAL_IRQ_OFF: nxt_status[FLAG_I] = 1'b0;
            // RULE_17 sign flag on
            OP_SIGN_FLAG_ON: nxt_status[FLAG_S] = 1'b1;
            default: nxt_state = state_ff;
         endcase
      end
      // RULE_01 RULE_02 fetch then store, status untouched
      unique case (state_ff)
         IO_IDLE: nxt_io_val = io_val_ff;
         IO_FETCH: begin
            nxt_io_val = io_ff[io_idx_ff];
            nxt_state = IO_STORE;
         end
         IO_STORE: begin
            nxt_io[io_idx_ff] = io_val_ff;
            nxt_io[io_idx_ff][io_bit_ff] = io_set_ff;
            nxt_state = IO_IDLE;
         end
         default: nxt_state = IO_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= IO_IDLE;
         operand_ff <= OPERAND_RST;
         status_ff <= STATUS_RST;
         io_ff <= '{default: IO_RST};
         io_idx_ff <= '0;
         io_bit_ff <= 3'h0;
         io_set_ff <= 1'b0;
         io_val_ff <= IO_RST;
         prdata_ff <= 32'h0;
      end else begin
         state_ff <= nxt_state;
         operand_ff <= nxt_operand;
         status_ff <= nxt_status;
         io_ff <= nxt_io;
         io_idx_ff <= nxt_io_idx;
         io_bit_ff <= nxt_io_bit;
         io_set_ff <= nxt_io_set;
         io_val_ff <= nxt_io_val;
         prdata_ff <= nxt_prdata;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [7:0] prev_op_ff;
   logic [7:0] prev_st_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_op_ff <= 8'h00;
         prev_st_ff <= 8'h00;
      end else begin
         prev_op_ff <= operand_ff;
         prev_st_ff <= status_ff;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_io_clear_seq: assert property ( // RULE_01
      exec && cmd_op == OP_IO_BIT_CLEAR |=> (state_ff == IO_FETCH && $stable(status_ff))
      ##1 (state_ff == IO_STORE && $stable(status_ff))
      ##1 (state_ff == IO_IDLE && !io_ff[io_idx_ff][io_bit_ff] && $stable(status_ff)))
      else $error("io bit clear sequence wrong");
   a_io_set_seq: assert property ( // RULE_02
      exec && cmd_op == OP_IO_BIT_FORCE_ONE |=> ##2
      (state_ff == IO_IDLE && io_ff[io_idx_ff][io_bit_ff] && status_ff == $past(status_ff, 3)))
      else $error("io bit set sequence wrong");
   a_shift_left: assert property ( // RULE_03
      exec && cmd_op == OP_LOGIC_SHIFT_LEFT |=>
      operand_ff == {prev_op_ff[6:0], 1'b0} && status_ff[FLAG_C] == prev_op_ff[7])
      else $error("shift left result wrong");
   a_shift_right: assert property ( // RULE_04
      exec && cmd_op == OP_LOGIC_SHIFT_RIGHT |=>
      operand_ff == {1'b0, prev_op_ff[7:1]} && status_ff[FLAG_C] == prev_op_ff[0])
      else $error("shift right result wrong");
   a_rotate_left: assert property ( // RULE_05
      exec && cmd_op == OP_ROTATE_LEFT_CARRY |=>
      operand_ff == {prev_op_ff[6:0], prev_st_ff[FLAG_C]} && status_ff[FLAG_C] == prev_op_ff[7])
      else $error("rotate left result wrong");
   a_rotate_right: assert property ( // RULE_06
      exec && cmd_op == OP_ROTATE_RIGHT_CARRY |=>
      operand_ff == {prev_st_ff[FLAG_C], prev_op_ff[7:1]} && status_ff[FLAG_C] == prev_op_ff[0])
      else $error("rotate right result wrong");
   a_arith_right: assert property ( // RULE_07
      exec && cmd_op == OP_ARITH_SHIFT_RIGHT |=> operand_ff == {prev_op_ff[7], prev_op_ff[7:1]})
      else $error("arithmetic shift result wrong");
   a_nibble_swap: assert property ( // RULE_08
      exec && cmd_op == OP_NIBBLE_EXCHANGE |=>
      operand_ff == {prev_op_ff[3:0], prev_op_ff[7:4]} && $stable(status_ff))
      else $error("nibble exchange wrong");
   a_transfer_in: assert property ( // RULE_11
      exec && cmd_op == OP_BIT_TO_TRANSFER_FLAG |=>
      status_ff[FLAG_T] == prev_op_ff[$past(cmd_bit)]
      && {status_ff[7], status_ff[5:0]} == {prev_st_ff[7], prev_st_ff[5:0]})
      else $error("transfer flag load wrong");
   a_transfer_out: assert property ( // RULE_12
      exec && cmd_op == OP_TRANSFER_FLAG_TO_BIT |=>
      operand_ff[$past(cmd_bit)] == prev_st_ff[FLAG_T] && $stable(status_ff))
      else $error("bit load wrong");
   a_neg_off: assert property ( // RULE_14
      exec && cmd_op == OP_NEGATIVE_FLAG_OFF |=>
      status_ff == (prev_st_ff & 8'hfb))
      else $error("negative clear wrong");
   a_irq_flag: assert property ( // RULE_16
      exec && cmd_op == OP_GLOBAL_IRQ_OFF |=> !global_irq_en ##0 status_q[6:0] == prev_st_ff[6:0])
      else $error("interrupt disable wrong");
   a_shift_flags: assert property ( // RULE_18
      exec && cmd_op inside {[OP_LOGIC_SHIFT_LEFT:OP_ARITH_SHIFT_RIGHT]} |=>
      status_ff[FLAG_Z] == (operand_ff == 8'h00) && status_ff[FLAG_N] == operand_ff[7]
      && status_ff[FLAG_V] == (status_ff[FLAG_N] ^ status_ff[FLAG_C]))
      else $error("shift flags wrong");

   c_io_clear: cover property (exec && cmd_op == OP_IO_BIT_CLEAR ##3 !busy);
   c_rotate_carry: cover property (exec && cmd_op == OP_ROTATE_LEFT_CARRY && status_ff[FLAG_C]);
   c_write_stall: cover property (psel && penable && pwrite && !pready);

endmodule : bit_shift_flag_unit

// [verification/apb_host_model.sv]
/*
 apb host model standing in for the core side of the unit's register bus.
 assumes pclk comes from the bench and that calls come from the bench.
*/
`timescale 1ns/1ns
module apb_host_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   bit chained;
   int unsigned stalls;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end

   // ----------------------------------------------------------------
   // one transfer
   // ----------------------------------------------------------------
   // request held until pready is high at a rising edge; keep leaves psel
   // up so that the next setup cycle follows at once
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input bit keep, output logic [31:0] q, output logic err);
      if (!chained) begin
         @(posedge pclk);
         psel <= 1'b1;
      end
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         stalls++;
         @(posedge pclk);
      end
      q = prdata;
      err = pslverr;
      penable <= 1'b0;
      chained = keep;
      if (!keep) begin
         psel <= 1'b0;
         // released data no longer shows the last value
         pwdata <= ~d;
      end
   endtask : xfer
endmodule : apb_host_model

// [verification/test_bit_shift_flag_unit.sv]
/*
 self-checking bench for the bit, shift and flag unit.
 assumes the apb host model and the unit's package are compiled first.
*/
`timescale 1ns/1ns
module test_bit_shift_flag_unit import bsfu_pkg::*; ;
   logic pclk;
   logic presetn;
   logic psel, penable, pwrite, pready, pslverr, global_irq_en, busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, v;
   logic [7:0] status_q, operand_q, d, s;
   logic [15:0] exp;
   logic [4:0] op;
   logic [2:0] b;
   logic [3:0] io;
   logic e;
   int num_errors, n_checks, cycles;
   int unsigned st;

   bit_shift_flag_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .status_q(status_q), .operand_q(operand_q),
      .global_irq_en(global_irq_en), .busy(busy));
   apb_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] xp);
      n_checks++;
      if (seen !== xp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, xp, seen);
      end
   endtask : check

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] rq;
      logic re;
      host.xfer(1'b1, a, wd, 1'b0, rq, re);
   endtask : wr

   // write that leaves psel up so the next setup follows at once
   task automatic wr_chain(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] rq;
      logic re;
      host.xfer(1'b1, a, wd, 1'b1, rq, re);
   endtask : wr_chain

   task automatic rd(input logic [11:0] a, output logic [31:0] rq);
      logic re;
      host.xfer(1'b0, a, 32'h00000000, 1'b0, rq, re);
   endtask : rd

   function automatic logic [31:0] cmd(logic [4:0] o, logic [2:0] bs, logic [3:0] ix);
      return {16'h0000, ix, 1'b0, bs, 3'h0, o};
   endfunction : cmd

   // expected {operand, status} after one operation
   function automatic logic [15:0] model(logic [4:0] o, logic [7:0] x, logic [7:0] f,
                                         logic [2:0] bs);
      logic [7:0] r;
      logic c;
      r = x;
      c = f[FLAG_C];
      case (o)
         5'h03: {c, r} = {x, 1'b0};
         5'h04: {r, c} = {1'b0, x};
         5'h05: {c, r} = {x, f[FLAG_C]};
         5'h06: {r, c} = {f[FLAG_C], x};
         5'h07: {r, c} = {x[7], x};
         5'h08: r = {x[3:0], x[7:4]};
         5'h09: f[bs] = 1'b1;
         5'h0a: f[bs] = 1'b0;
         5'h0b: f[FLAG_T] = x[bs];
         5'h0c: r[bs] = f[FLAG_T];
         5'h0d: f[FLAG_C] = 1'b1;
         5'h0e: f[FLAG_C] = 1'b0;
         5'h0f: f[FLAG_N] = 1'b1;
         5'h10: f[FLAG_N] = 1'b0;
         5'h11: f[FLAG_Z] = 1'b1;
         5'h12: f[FLAG_Z] = 1'b0;
         5'h13: f[FLAG_I] = 1'b1;
         5'h14: f[FLAG_I] = 1'b0;
         5'h15: f[FLAG_S] = 1'b1;
         default: r = x;
      endcase
      if (o >= 5'h03 && o <= 5'h07) begin
         f[FLAG_C] = c;
         f[FLAG_Z] = (r == 8'h00);
         f[FLAG_N] = r[7];
         f[FLAG_V] = r[7] ^ c;
      end
      return {r, f};
   endfunction : model

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_sim();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      void'($urandom(15));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_STATUS, q);
      check("status_rst", q, {24'h0, STATUS_RST});
      rd(ADDR_IO_BASE, q);
      check("io_rst", q, {24'h0, IO_RST});
      rd(ADDR_STATE, q);
      check("state_rst", q, 32'h00000000);
      host.xfer(1'b0, 12'h020, 32'h00000000, 1'b0, q, e);
      check("unmapped_err", {31'h0, e}, 32'h00000001);
      $display("test reset and map done");
      for (int i = 0; i < 200; i++) begin
         op = (i < 19) ? 5'(i + 3) : 5'($urandom_range(21, 3));
         d = (i % 7 == 0) ? 8'h80 : 8'($urandom);
         s = 8'($urandom);
         b = 3'($urandom);
         exp = model(op, d, s, b);
         wr(ADDR_OPERAND, {24'h0, d});
         wr(ADDR_STATUS, {24'h0, s});
         wr(ADDR_CMD, cmd(op, b, 4'h0));
         @(negedge pclk);
         check("operand", {24'h0, operand_q}, {24'h0, exp[15:8]});
         check("status", {24'h0, status_q}, {24'h0, exp[7:0]});
         check("irq_en", {31'h0, global_irq_en}, {31'h0, exp[7]});
      end
      wr(ADDR_CMD, cmd(5'h1f, 3'h0, 4'h0));
      rd(ADDR_STATUS, q);
      check("bad_op", q, {24'h0, exp[7:0]});
      $display("test operations done");
      for (int i = 0; i < 20; i++) begin
         io = 4'($urandom_range(7));
         b = 3'($urandom);
         v = {24'h0, 8'($urandom)};
         s = 8'($urandom);
         op = (i % 2 == 0) ? 5'h01 : 5'h02;
         wr(ADDR_IO_BASE + 12'(4 * io), v);
         wr(ADDR_STATUS, {24'h0, s});
         wr(ADDR_CMD, cmd(op, b, io));
         v[b] = op[1];
         @(negedge pclk);
         check("busy_c1", {31'h0, busy}, 32'h00000001);
         @(negedge pclk);
         check("busy_c2", {31'h0, busy}, 32'h00000001);
         @(negedge pclk);
         check("busy_end", {31'h0, busy}, 32'h00000000);
         rd(ADDR_IO_BASE + 12'(4 * io), q);
         check("io_bit", q, v);
         check("io_flags", {24'h0, status_q}, {24'h0, s});
      end
      $display("test io bit done");
      for (int i = 0; i < 4; i++) begin
         io = 4'($urandom_range(7));
         b = 3'($urandom);
         v = {24'h0, 8'($urandom)};
         d = 8'($urandom);
         op = (i % 2 == 0) ? 5'h01 : 5'h02;
         wr(ADDR_IO_BASE + 12'(4 * io), v);
         wr_chain(ADDR_CMD, cmd(op, b, io));
         st = host.stalls;
         wr(ADDR_OPERAND, {24'h0, d});
         check("stall_waits", 32'(host.stalls - st), 32'h00000001);
         v[b] = op[1];
         rd(ADDR_IO_BASE + 12'(4 * io), q);
         check("io_after_stall", q, v);
         rd(ADDR_OPERAND, q);
         check("stalled_write", q, {24'h0, d});
      end
      $display("test write stall done");
      end_sim();
   end
endmodule : test_bit_shift_flag_unit
